// [bfs_board.sv]
// board model: enable divider with hysteresis and power-ok pull-up
`timescale 1ns/100ps
module bfs_board (
   // enable level: 0 low, 1 inside hysteresis band, 2 high
   input wire logic [1:0] en_lvl_i,
   // open-drain power ok pin
   input wire logic pg_data_i,
   input wire logic pg_oe_n_i,
   // board views
   output logic above_on_o,
   output logic above_off_o,
   output logic pg_seen_o
);
   assign above_on_o = (en_lvl_i == 2'h2);
   assign above_off_o = (en_lvl_i != 2'h0);
   // released pin floats up through the pull-up
   assign pg_seen_o = pg_oe_n_i ? 1'b1 : pg_data_i;
endmodule

// [bfs_pkg.sv]
// package: constants and carrier types of the buck fault supervisor
package bfs_pkg;
   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned PG_DEGLITCH_US = 200;
   localparam int unsigned UV_WAIT_US = 1000;
   localparam int unsigned HICCUP_US = 7000;
   localparam int unsigned MODE_READ_US = 200;
   localparam int unsigned PG_DEGLITCH_CYC = PG_DEGLITCH_US * (CLK_HZ / 1_000_000);
   localparam int unsigned UV_WAIT_CYC = UV_WAIT_US * (CLK_HZ / 1_000_000);
   localparam int unsigned HICCUP_CYC = HICCUP_US * (CLK_HZ / 1_000_000);
   localparam int unsigned MODE_READ_CYC = MODE_READ_US * (CLK_HZ / 1_000_000);
   localparam int unsigned CNT_W = 24;

   // ---------------------------------------------------------------
   // register map (word offsets in bytes)
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_MODE = 4'h8;
   localparam logic [3:0] REG_ID = 4'hC;
   // ctrl field positions
   localparam int unsigned CTRL_SW_EN_BIT = 0;
   localparam logic [31:0] CTRL_RST = 32'h0000_0001;
   // arbitrary identification value
   localparam logic [31:0] ID_VALUE = 32'h0000_5A01;
   // status field positions
   localparam int unsigned ST_STATE_LSB = 0;
   localparam int unsigned ST_PG_BIT = 4;
   localparam int unsigned ST_DIS_BIT = 5;
   localparam int unsigned ST_MODE_OK_BIT = 6;
   localparam int unsigned ST_OOB_BIT = 7;
   localparam int unsigned ST_BIAS_OFF_BIT = 8;
   localparam int unsigned ST_UVT_BIT = 9;
   // mode word: [0] pulse skip, [1] lower current limit, [3:2] frequency
   localparam int unsigned MODE_W = 4;
   localparam logic [MODE_W-1:0] MODE_RST = 4'h0;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_OFF,
      ST_MODE_READ,
      ST_SOFT_START,
      ST_RUN,
      ST_UV_WAIT,
      ST_HICCUP,
      ST_THERMAL
   } bfs_state_e;

   // comparator decisions from the analog stage
   typedef struct packed {
      logic enable_above_on;
      logic enable_above_off;
      logic bias_ok;
      logic thermal_trip;
      logic second_thermal_trip;
      logic fb_in_window;
      logic fb_below_uv;
      logic fb_above_ov;
      logic fb_above_oob;
      logic valley_over_limit;
      logic valley_below_zero;
      logic ref_above_fb;
      logic ss_done;
   } bfs_cmp_s;

   // commands to the power stage
   typedef struct packed {
      logic switching_en;
      logic low_side_force;
      logic pulse_skip_en;
      logic neg_limit_en;
      logic ss_reset;
      logic discharge_en;
      logic bias_rail_off;
      logic ref_external_sel;
   } bfs_drv_s;
endpackage

// [bfs_supervisor.sv]
// buck fault supervisor: sequencing, protection, power-good and register slave
//--------------------------------------------------------------------
// Summary of operation
// - power ok after 200us in 93-107% window
// - power ok low on trips, thermal, soft-start
// - undervoltage lasting 1 ms shuts down
// - hiccup off 7 ms then restart
// - current limit in start-up skips wait
// - hold low side while valley over limit
// - 8% over forces low side, no fault
// - negative limit on during out-of-bounds
// - bias lockout shuts off, auto resumes
// - thermal trip shuts off, non-latching
// - thermal at start: no switching, no mode
// - thermal later: stop, ground ss, discharge
// - thermal recovery resumes, mode kept
// - second thermal trip turns bias rail off
// - discharge on faults and enable low
// - enable hysteresis between on and off thresholds
// - ss starts with enable, lower ramp wins
// - pre-bias waits for reference above feedback
// - continuous or pulse skip per mode
// - mode latch cleared only by power cycle
// - ramp only after mode read completes
//--------------------------------------------------------------------
`timescale 1ns/100ps
module bfs_supervisor
   import bfs_pkg::*;
#(
   parameter int unsigned PG_DEGLITCH_CYCLES = PG_DEGLITCH_CYC,
   parameter int unsigned UV_WAIT_CYCLES = UV_WAIT_CYC,
   parameter int unsigned HICCUP_CYCLES = HICCUP_CYC,
   parameter int unsigned MODE_READ_CYCLES = MODE_READ_CYC
) (
   // clock and reset (reset models input supply power-up)
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // analog comparator decisions, asynchronous
   input wire bfs_cmp_s cmp_i,
   input wire logic [MODE_W-1:0] mode_pins_i,
   input wire logic ext_ss_lower_i,
   // power stage commands
   output bfs_drv_s drv_o,
   // open-drain power ok: enable low means pulled low
   output logic power_ok_output_o,
   output logic power_ok_output_oe_n_o,
   // avalon-mm slave
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o
);

   //-----------------------------------------------------------------
   // input synchronisers
   //-----------------------------------------------------------------
   localparam int unsigned SYN_W = $bits(bfs_cmp_s) + MODE_W + 1;
   logic [SYN_W-1:0] syn1_q;
   logic [SYN_W-1:0] syn2_q;
   bfs_cmp_s c;
   logic [MODE_W-1:0] mode_pins_s;
   logic ext_ss_lower_s;

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         syn1_q <= '0;
         syn2_q <= '0;
      end else begin
         syn1_q <= {cmp_i, mode_pins_i, ext_ss_lower_i};
         syn2_q <= syn1_q;
      end
   end
   assign {c, mode_pins_s, ext_ss_lower_s} = syn2_q;

   //-----------------------------------------------------------------
   // enable hysteresis and shutdown conditions
   //-----------------------------------------------------------------
   logic en_q;
   logic en_d;
   logic sw_en_q;
   // on above the upper comparator, off below the lower one
   assign en_d = c.enable_above_on ? 1'b1 : (c.enable_above_off ? en_q : 1'b0);

   wire run_req = en_q && sw_en_q && c.bias_ok && !c.second_thermal_trip;
   wire bias_off_w = c.second_thermal_trip;

   //-----------------------------------------------------------------
   // sequencer
   //-----------------------------------------------------------------
   bfs_state_e state_q;
   bfs_state_e state_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic mode_ok_q;
   logic [MODE_W-1:0] mode_q;
   logic uv_trip_q;

   wire cnt_is_0 = (cnt_q == '0);

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_is_0 ? cnt_q : cnt_q - 1'b1;
      if (!run_req) begin
         state_d = ST_OFF;
         cnt_d = '0;
      end else begin
         case (state_q)
            ST_OFF: begin
               if (c.thermal_trip) begin
                  state_d = ST_OFF;
               end else if (mode_ok_q) begin
                  state_d = ST_SOFT_START;
               end else begin
                  state_d = ST_MODE_READ;
                  cnt_d = CNT_W'(MODE_READ_CYCLES);
               end
            end
            ST_MODE_READ: begin
               if (c.thermal_trip) begin
                  state_d = ST_OFF;
               end else if (cnt_is_0) begin
                  state_d = ST_SOFT_START;
               end
            end
            ST_SOFT_START: begin
               if (c.thermal_trip) begin
                  state_d = ST_THERMAL;
               end else if (c.valley_over_limit) begin
                  state_d = ST_HICCUP;
                  cnt_d = CNT_W'(HICCUP_CYCLES);
               end else if (c.ss_done) begin
                  state_d = ST_RUN;
               end
            end
            ST_RUN: begin
               if (c.thermal_trip) begin
                  state_d = ST_THERMAL;
               end else if (c.fb_below_uv) begin
                  state_d = ST_UV_WAIT;
                  cnt_d = CNT_W'(UV_WAIT_CYCLES);
               end
            end
            ST_UV_WAIT: begin
               if (c.thermal_trip) begin
                  state_d = ST_THERMAL;
               end else if (!c.fb_below_uv) begin
                  state_d = ST_RUN;
               end else if (cnt_is_0) begin
                  state_d = ST_HICCUP;
                  cnt_d = CNT_W'(HICCUP_CYCLES);
               end
            end
            ST_HICCUP: begin
               // restart goes back through soft start; repeats while fault stays
               if (cnt_is_0) begin
                  state_d = ST_SOFT_START;
               end
            end
            ST_THERMAL: begin
               if (!c.thermal_trip) begin
                  state_d = ST_SOFT_START;
               end
            end
            default: begin
               state_d = ST_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_q <= ST_OFF;
         cnt_q <= '0;
         en_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         en_q <= en_d;
      end
   end

   //-----------------------------------------------------------------
   // state decode
   //-----------------------------------------------------------------
   // one named wire per state except ST_THERMAL keeps command and status logic readable
   wire in_off = (state_q == ST_OFF);
   wire in_mode_read = (state_q == ST_MODE_READ);
   wire in_soft_start = (state_q == ST_SOFT_START);
   wire in_run = (state_q == ST_RUN);
   wire in_uv_wait = (state_q == ST_UV_WAIT);
   wire in_hiccup = (state_q == ST_HICCUP);
   // strap sampled on the last cycle of the read window only
   wire mode_done = in_mode_read && (state_d == ST_SOFT_START);

   // mode latched once per supply cycle; only reset clears it
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mode_ok_q <= 1'b0;
         mode_q <= MODE_RST;
      end else if (mode_done) begin
         mode_ok_q <= 1'b1;
         mode_q <= mode_pins_s;
      end
   end

   //-----------------------------------------------------------------
   // power ok deglitch
   //-----------------------------------------------------------------
   logic [CNT_W-1:0] pg_cnt_q;
   logic pg_q;
   // undervoltage trip spans the wait and the hiccup after it
   wire uvt_w = in_uv_wait || in_hiccup;
   // fault sources for power ok and the discharge switch; only ov and hot feed both
   wire uv_fault = c.fb_below_uv;
   wire ov_fault = c.fb_above_ov;
   wire hot_fault = c.thermal_trip;
   wire bias_low = !c.bias_ok;
   wire enable_low = !en_q;
   wire pg_block = uv_fault || ov_fault || hot_fault || !in_run;
   wire pg_win = c.fb_in_window && !pg_block;

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pg_cnt_q <= '0;
         pg_q <= 1'b0;
         uv_trip_q <= 1'b0;
      end else begin
         uv_trip_q <= uvt_w;
         if (!pg_win) begin
            pg_cnt_q <= '0;
            pg_q <= 1'b0;
         end else if (pg_cnt_q >= CNT_W'(PG_DEGLITCH_CYCLES - 1)) begin
            pg_q <= 1'b1;
         end else begin
            pg_cnt_q <= pg_cnt_q + 1'b1;
         end
      end
   end

   //-----------------------------------------------------------------
   // power stage commands
   //-----------------------------------------------------------------
   // the stage runs in soft start, run and the undervoltage wait
   wire active = in_soft_start || in_run || in_uv_wait;
   wire prebias_hold = in_soft_start && !c.ref_above_fb;
   wire out_of_bounds_guard = active && c.fb_above_oob;
   // per-field command decode
   wire switch_cmd = active && !prebias_hold;
   // valley limit and out-of-bounds both hold the low side on
   wire low_side_cmd = active && (c.valley_over_limit || out_of_bounds_guard);
   // out-of-bounds forces pwm, so skipping waits until it clears
   wire skip_cmd = active && mode_q[0] && !out_of_bounds_guard && c.valley_below_zero;
   wire discharge_cmd = ov_fault || uvt_w || hot_fault || bias_low || enable_low || in_off;
   bfs_drv_s drv_d;

   always_comb begin
      drv_d = '0;
      drv_d.switching_en = switch_cmd;
      drv_d.low_side_force = low_side_cmd;
      drv_d.neg_limit_en = out_of_bounds_guard;
      drv_d.pulse_skip_en = skip_cmd;
      drv_d.ss_reset = !active;
      drv_d.discharge_en = discharge_cmd;
      drv_d.bias_rail_off = bias_off_w;
      drv_d.ref_external_sel = ext_ss_lower_s;
   end

   //-----------------------------------------------------------------
   // avalon-mm slave: one wait cycle, answer on the second
   //-----------------------------------------------------------------
   logic ack_q;
   logic [31:0] ctrl_q;
   logic [31:0] status_w;
   logic [31:0] rd_mux;
   // address decode; anything unmapped reads zero and ignores writes
   wire sel_ctrl = (avs_address_i == REG_CTRL);
   wire sel_status = (avs_address_i == REG_STATUS);
   wire sel_mode = (avs_address_i == REG_MODE);
   wire sel_id = (avs_address_i == REG_ID);
   // taken once; the answer cycle blocks a second take of the same request
   wire req = (avs_read_i || avs_write_i) && !ack_q;
   // writes land on the answer edge, where the master sees waitrequest low
   wire wr_ctrl = ack_q && avs_write_i && sel_ctrl;

   assign status_w = {22'h0, uv_trip_q, bias_off_w, out_of_bounds_guard, mode_ok_q, drv_o.discharge_en,
                      pg_q, 1'b0, state_q};
   assign rd_mux = sel_ctrl ? ctrl_q :
                   sel_status ? status_w :
                   sel_mode ? {28'h0, mode_q} :
                   sel_id ? ID_VALUE : 32'h0000_0000;

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ack_q <= 1'b0;
         ctrl_q <= CTRL_RST;
         sw_en_q <= 1'b1;
         avs_readdata_o <= '0;
         avs_waitrequest_o <= 1'b1;
      end else begin
         ack_q <= req;
         avs_waitrequest_o <= !req;
         if (req && avs_read_i) begin
            avs_readdata_o <= rd_mux;
         end
         if (wr_ctrl && avs_byteenable_i[0]) begin
            ctrl_q[7:0] <= avs_writedata_i[7:0];
            sw_en_q <= avs_writedata_i[CTRL_SW_EN_BIT];
         end
      end
   end

   //-----------------------------------------------------------------
   // registered outputs
   //-----------------------------------------------------------------
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         drv_o <= '0;
         power_ok_output_o <= 1'b0;
         power_ok_output_oe_n_o <= 1'b0;
      end else begin
         drv_o <= drv_d;
         power_ok_output_o <= 1'b0;
         // released (floating) only while power is good
         power_ok_output_oe_n_o <= pg_q;
      end
   end
endmodule

// [bfs_supervisor_chk.sv]
// checker: port-level properties of the buck fault supervisor
`timescale 1ns/100ps
module bfs_supervisor_chk
   import bfs_pkg::*;
#(
   parameter int unsigned PG_DEGLITCH_CYCLES = PG_DEGLITCH_CYC
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // watched ports
   input wire bfs_cmp_s cmp_i,
   input wire bfs_drv_s drv_o,
   input wire logic power_ok_output_oe_n_o
);
   // consecutive in-window cycles, saturating so a long run never wraps
   logic [15:0] win_q;
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         win_q <= 16'h0000;
      end else if (!cmp_i.fb_in_window) begin
         win_q <= 16'h0000;
      end else if (win_q != 16'hffff) begin
         win_q <= win_q + 16'h0001;
      end
   end
   default clocking @(posedge mclk_i);
   endclocking
   default disable iff (sys_rst_i);
   // a fault level held long enough to pass the input synchroniser
   sequence hot_s; cmp_i.thermal_trip [*4]; endsequence
   sequence uv_s; cmp_i.fb_below_uv [*4]; endsequence
   pg_deglitch_a: assert property ($rose(power_ok_output_oe_n_o) |-> win_q >= PG_DEGLITCH_CYCLES)
      else $error("power ok released early");
   uv_pg_low_a: assert property (uv_s |=> !power_ok_output_oe_n_o)
      else $error("power ok high in undervoltage");
   hot_pg_low_a: assert property (hot_s |=> !power_ok_output_oe_n_o)
      else $error("power ok high when hot");
   hot_stop_a: assert property (hot_s |=> !drv_o.switching_en && drv_o.discharge_en)
      else $error("switching while hot");
   bias_lock_a: assert property ((!cmp_i.bias_ok) [*4] |=> !drv_o.switching_en && drv_o.discharge_en)
      else $error("switching without bias");
   enable_off_a: assert property ((!cmp_i.enable_above_off) [*4] |=> drv_o.discharge_en)
      else $error("no discharge with enable low");
   bias_rail_a: assert property (cmp_i.second_thermal_trip [*4] |=> drv_o.bias_rail_off)
      else $error("bias rail kept on");
   oob_force_a: assert property ((cmp_i.fb_above_oob && drv_o.switching_en) [*5] |=> drv_o.low_side_force && drv_o.neg_limit_en)
      else $error("out of bounds not handled");
   valley_hold_a: assert property ((cmp_i.valley_over_limit && drv_o.switching_en) [*5] |=> drv_o.low_side_force)
      else $error("low side released over limit");
endmodule

// [testbench.sv]
// testbench: directed scenarios for the buck fault supervisor
`timescale 1ns/100ps
module testbench
   import bfs_pkg::*;
;
   localparam int unsigned PGD = 8;
   localparam int unsigned UVW = 16;
   localparam int unsigned HIC = 32;
   localparam int unsigned MRD = 8;
   logic mclk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [1:0] en_lvl = 2'h0;
   logic [3:0] mode_pins = 4'h1;
   logic ext_lower = 1'b0;
   logic rd_v = 1'b0;
   logic wr_v = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata, d;
   logic pg_data, pg_oe_n, pg_seen, en_on, en_off, wait_v;
   bfs_cmp_s cmp_q, cmp_w;
   bfs_drv_s drv;
   int errors = 0;
   int num_checks = 0;
   int cyc = 0;
   int t;
   always_comb begin
      cmp_w = cmp_q;
      cmp_w.enable_above_on = en_on;
      cmp_w.enable_above_off = en_off;
   end
   bfs_board bfs_board_inst (.en_lvl_i(en_lvl), .pg_data_i(pg_data), .pg_oe_n_i(pg_oe_n),
      .above_on_o(en_on), .above_off_o(en_off), .pg_seen_o(pg_seen));
   bfs_supervisor #(.PG_DEGLITCH_CYCLES(PGD), .UV_WAIT_CYCLES(UVW), .HICCUP_CYCLES(HIC), .MODE_READ_CYCLES(MRD))
      bfs_supervisor_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cmp_i(cmp_w), .mode_pins_i(mode_pins),
      .ext_ss_lower_i(ext_lower), .drv_o(drv), .power_ok_output_o(pg_data), .power_ok_output_oe_n_o(pg_oe_n),
      .avs_address_i(addr), .avs_read_i(rd_v), .avs_write_i(wr_v), .avs_writedata_i(wdata),
      .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_v));
   initial begin
      forever #2.5 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         results();
      end
   end
   task automatic results();
      if (errors == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic tick();
      repeat (6) @(posedge mclk_i);
   endtask
   // one avalon access, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
      @(posedge mclk_i);
      addr <= a;
      wdata <= v;
      rd_v <= !w;
      wr_v <= w;
      do @(posedge mclk_i); while (wait_v !== 1'b0);
      d = rdata;
      rd_v <= 1'b0;
      wr_v <= 1'b0;
   endtask
   task automatic wait_st(input logic [2:0] s);
      int n;
      n = 0;
      do begin
         bus(1'b0, REG_STATUS, 32'h0000_0000);
         n++;
      end while (d[2:0] !== s && n < 200);
      chk("state", 32'(d[2:0]), 32'(s));
   endtask
   task automatic t_start();
      cmp_q.bias_ok <= 1'b1;
      en_lvl <= 2'h2;
      t = cyc;
      wait_st(ST_SOFT_START);
      chk("mode_read", 32'(cyc - t >= MRD), 32'h1);
      chk("pg_ss", 32'(pg_seen), 32'h0);
      ext_lower <= 1'b1;
      tick();
      chk("ref_sel", 32'(drv.ref_external_sel), 32'h1);
      cmp_q.ss_done <= 1'b1;
      cmp_q.fb_in_window <= 1'b1;
      wait_st(ST_RUN);
      chk("no_skip", 32'(drv.pulse_skip_en), 32'h0);
      cmp_q.valley_below_zero <= 1'b1;
      tick();
      chk("pulse_skip", 32'(drv.pulse_skip_en), 32'h1);
      cmp_q.fb_in_window <= 1'b0;
      tick();
      chk("pg_out", 32'(pg_seen), 32'h0);
      cmp_q.fb_in_window <= 1'b1;
      t = cyc;
      while (pg_seen !== 1'b1 && cyc - t < 100) @(posedge mclk_i);
      chk("deglitch", 32'(cyc - t >= PGD), 32'h1);
      chk("pg_on", 32'(pg_seen), 32'h1);
      cmp_q.valley_over_limit <= 1'b1;
      tick();
      chk("valley", 32'(drv.low_side_force), 32'h1);
      cmp_q.valley_over_limit <= 1'b0;
      cmp_q.fb_above_oob <= 1'b1;
      tick();
      chk("oob", 32'({drv.low_side_force, drv.neg_limit_en, drv.switching_en}), 32'h7);
      cmp_q.fb_above_oob <= 1'b0;
   endtask
   task automatic t_uv();
      cmp_q.fb_below_uv <= 1'b1;
      cmp_q.fb_in_window <= 1'b0;
      cmp_q.ss_done <= 1'b0;
      cmp_q.ref_above_fb <= 1'b0;
      t = cyc;
      tick();
      chk("pg_uv", 32'(pg_seen), 32'h0);
      wait_st(ST_HICCUP);
      chk("uv_wait", 32'(cyc - t >= UVW), 32'h1);
      chk("dis_uv", 32'({drv.discharge_en, drv.switching_en}), 32'h2);
      cmp_q.fb_below_uv <= 1'b0;
      t = cyc;
      wait_st(ST_SOFT_START);
      chk("hiccup", 32'(cyc - t + 4 >= HIC), 32'h1);
      tick();
      chk("prebias", 32'(drv.switching_en), 32'h0);
      cmp_q.ref_above_fb <= 1'b1;
      tick();
      chk("ramp", 32'(drv.switching_en), 32'h1);
      cmp_q.valley_over_limit <= 1'b1;
      t = cyc;
      wait_st(ST_HICCUP);
      chk("ss_limit", 32'(cyc - t < UVW), 32'h1);
      cmp_q.valley_over_limit <= 1'b0;
      cmp_q.ss_done <= 1'b1;
      cmp_q.fb_in_window <= 1'b1;
      wait_st(ST_RUN);
   endtask
   task automatic t_hot();
      mode_pins <= 4'h0;
      cmp_q.thermal_trip <= 1'b1;
      tick();
      chk("hot", 32'({drv.switching_en, drv.ss_reset, drv.discharge_en, pg_seen}), 32'h6);
      cmp_q.thermal_trip <= 1'b0;
      wait_st(ST_RUN);
      chk("mode_kept", 32'(drv.pulse_skip_en), 32'h1);
   endtask
   task automatic t_standby();
      bus(1'b1, REG_CTRL, 32'h0000_0000);
      wait_st(ST_OFF);
      chk("dis_off", 32'(drv.discharge_en), 32'h1);
      bus(1'b1, REG_CTRL, 32'h0000_0001);
      bus(1'b0, 4'h2, 32'h0000_0000);
      chk("unmapped", d, 32'h0000_0000);
      bus(1'b0, REG_ID, 32'h0000_0000);
      chk("id", d, ID_VALUE);
      wait_st(ST_RUN);
      en_lvl <= 2'h1;
      tick();
      chk("band", 32'(drv.switching_en), 32'h1);
      en_lvl <= 2'h0;
      wait_st(ST_OFF);
      bus(1'b0, REG_MODE, 32'h0000_0000);
      chk("mode", d, 32'h0000_0001);
      cmp_q.thermal_trip <= 1'b1;
      cmp_q.second_thermal_trip <= 1'b1;
      tick();
      chk("bias_off", 32'(drv.bias_rail_off), 32'h1);
      // supply cycle while hot: latch cleared, mode not loaded again
      sys_rst_i <= 1'b1;
      cmp_q.second_thermal_trip <= 1'b0;
      en_lvl <= 2'h2;
      mode_pins <= 4'h1;
      tick();
      sys_rst_i <= 1'b0;
      repeat (3) tick();
      chk("hot_sw", 32'(drv.switching_en), 32'h0);
      bus(1'b0, REG_STATUS, 32'h0000_0000);
      chk("hot_start", d, 32'h0000_0020);
      bus(1'b0, REG_MODE, 32'h0000_0000);
      chk("mode_clr", d, 32'(MODE_RST));
   endtask
   initial begin
      cmp_q = '0;
      cmp_q.ref_above_fb = 1'b1;
      repeat (2) @(posedge mclk_i);
      chk("reset", 32'({pg_oe_n, wait_v, drv}), 32'h0000_0100);
      @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      tick();
      t_start();
      t_uv();
      t_hot();
      t_standby();
      results();
   end
endmodule
bind bfs_supervisor bfs_supervisor_chk #(.PG_DEGLITCH_CYCLES(PG_DEGLITCH_CYCLES)) bfs_supervisor_chk_inst (
   .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cmp_i(cmp_i), .drv_o(drv_o),
   .power_ok_output_oe_n_o(power_ok_output_oe_n_o));
